// ---- inc/tor_pkg.sv ----
package tor_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned PWR_REMOVAL_MS = 15;
  localparam int unsigned EXCITE_MAX_MS = 10;
  localparam int unsigned LOCKOUT_MAX_MS = 100;
  localparam logic [6:0] LOCKOUT_DEFAULT_MS = 7'h00;
  localparam int unsigned MS_CNT_W = 15;
  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);
  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  localparam logic [1:0] CLR_ON_EDGE = 2'h1;
  localparam logic [1:0] CLR_ON_LEVEL = 2'h2;
  localparam logic CLR_MODE_DEFAULT_IS_EDGE = 1'b1;
  localparam logic ALARM_MODE_NONE = 1'b0;
  localparam logic ALM_CLR_EXCITE_DEFAULT = 1'b0;
  localparam logic SON_EXCITE_DEFAULT = 1'b1;
  localparam logic STOP_EXCITE_DEFAULT = 1'b1;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TOR_EXCITED = 2'b00,
    TOR_REMOVED = 2'b01,
    TOR_RELEASED = 2'b10
  } tor_state_t;
endpackage

// ---- rtl/tor_core.sv ----
// Notes on behaviour
// - input-off monitor on when either input off
// - torque-off monitor set on input off, mode 0
// - torque-off monitor cleared by accepted clear
// - dual-off monitor only while both off
// - clear input re-excites only with servo-on
// - clear judged on rising edge or level
// - clear ignored during lockout after both on
// - excitation follows acceptance within ten ms
// - alarm-clear rising edge may re-excite, optional
// - servo-on may re-excite, enabled by default
// - stop input may re-excite, enabled by default
// - external monitor off if one input stuck
// - both on at power-up: excite, monitor off
// - both off: de-excite, external monitor on
// - removal status within 15 ms of both off
// - no release while only one input on
// - ready, command-ready, brake off while removed
`timescale 1ns/10ps
module tor_core
  import tor_pkg::*;
#(
  parameter int unsigned LOCKOUT_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // safety inputs, high means on
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  // control inputs
  input wire logic servo_on,
  input wire logic torque_off_clear,
  input wire logic alarm_clear_input,
  input wire logic stop_input,
  // settings
  input wire logic alarm_mode,
  input wire logic [1:0] clear_mode,
  input wire logic [LOCKOUT_W-1:0] lockout_ms,
  input wire logic alm_clear_excite_en,
  input wire logic son_excite_en,
  input wire logic stop_excite_en,
  // monitors and drive outputs
  output logic safety_input_off_monitor,
  output logic torque_off_monitor,
  output logic dual_off_monitor,
  output logic external_device_monitor,
  output logic motor_excite,
  output logic drive_command_ready,
  output logic ready,
  output logic brake_control_output
);
  import tor_pkg::*;

  // the lockout counter must hold the longest setting
  if (LOCKOUT_W > 16 || (2 ** LOCKOUT_W) <= LOCKOUT_MAX_MS) begin : g_bad_lockout_w
    $error("tor_core: LOCKOUT_W must hold the longest lockout and be at most 16");
  end

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  // inputs are already synchronous; one stage plus a history stage gives clean edges
  logic a_reg, a_next;
  logic b_reg, b_next;
  logic son_reg, son_next;
  logic clr_reg, clr_next;
  logic alm_reg, alm_next;
  logic stop_reg, stop_next;
  logic son_prev_reg, son_prev_next;
  logic clr_prev_reg, clr_prev_next;
  logic alm_prev_reg, alm_prev_next;
  logic stop_prev_reg, stop_prev_next;

  always_comb begin
    a_next = safety_input_a;
    b_next = safety_input_b;
    son_next = servo_on;
    clr_next = torque_off_clear;
    alm_next = alarm_clear_input;
    stop_next = stop_input;
    son_prev_next = son_reg;
    clr_prev_next = clr_reg;
    alm_prev_next = alm_reg;
    stop_prev_next = stop_reg;
  end

  // safety channels reset as on, so leaving reset is not a removal event
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_reg <= 1'b1;
      b_reg <= 1'b1;
      son_reg <= 1'b0;
      clr_reg <= 1'b0;
      alm_reg <= 1'b0;
      stop_reg <= 1'b0;
      son_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
      alm_prev_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
    end else begin
      a_reg <= a_next;
      b_reg <= b_next;
      son_reg <= son_next;
      clr_reg <= clr_next;
      alm_reg <= alm_next;
      stop_reg <= stop_next;
      son_prev_reg <= son_prev_next;
      clr_prev_reg <= clr_prev_next;
      alm_prev_reg <= alm_prev_next;
      stop_prev_reg <= stop_prev_next;
    end
  end

  // a rise is a high sample after a low one
  function automatic logic rose_now(input logic now_level, input logic prev_level);
    return now_level & ~prev_level;
  endfunction

  logic a_on, b_on, both_on, both_off, one_off;
  logic son_on, clr_rise, clr_level, alm_rise, son_rise, stop_rise;
  assign a_on = a_reg;
  assign b_on = b_reg;
  assign both_on = a_on & b_on;
  assign both_off = ~a_on & ~b_on;
  assign one_off = ~both_on;
  assign son_on = son_reg;
  assign clr_level = clr_reg;
  assign clr_rise = rose_now(clr_reg, clr_prev_reg);
  assign alm_rise = rose_now(alm_reg, alm_prev_reg);
  assign son_rise = rose_now(son_reg, son_prev_reg);
  assign stop_rise = rose_now(stop_reg, stop_prev_reg);

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  // restarted while removed, so the first tick after release is a full one
  logic [MS_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  tor_state_t state_reg, state_next;
  assign tick = (tick_cnt_reg == MS_LAST);

  always_comb begin
    if (state_reg == TOR_REMOVED) begin
      tick_cnt_next = '0;
    end else if (tick) begin
      tick_cnt_next = '0;
    end else begin
      tick_cnt_next = tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // lockout
  // ----------------------------------------------------------------
  // settings beyond the range are held at the longest lockout
  logic [LOCKOUT_W-1:0] lockout_eff;
  logic [LOCKOUT_W-1:0] lock_cnt_reg, lock_cnt_next;
  logic lock_done;
  assign lockout_eff = (lockout_ms > LOCKOUT_W'(LOCKOUT_MAX_MS)) ? LOCKOUT_W'(LOCKOUT_MAX_MS) : lockout_ms;
  assign lock_done = (lock_cnt_reg >= lockout_eff);

  always_comb begin
    lock_cnt_next = lock_cnt_reg;
    if (state_reg == TOR_REMOVED) begin
      // restart so the window opens when both inputs come back
      lock_cnt_next = '0;
    end else if (tick && !lock_done) begin
      // saturates once done, so a long run never wraps it
      lock_cnt_next = lock_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_reg <= '0;
    end else begin
      lock_cnt_reg <= lock_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // excitation state
  // ----------------------------------------------------------------
  logic clr_ok, clr_accept, alm_accept, son_accept, stop_accept, accept;
  always_comb begin
    unique case (clear_mode)
      CLR_ON_LEVEL: clr_ok = clr_level;
      default: clr_ok = clr_rise;
    endcase
  end

  // lockout gates only the clear input; the other sources act at once
  assign clr_accept = clr_ok & son_on & lock_done;
  assign alm_accept = alm_clear_excite_en & alm_rise;
  assign son_accept = son_excite_en & son_rise;
  assign stop_accept = stop_excite_en & stop_rise;
  assign accept = clr_accept | alm_accept | son_accept | stop_accept;

  logic tom_reg, tom_next;

  // set wins: a drop in the accept cycle keeps the monitor on
  always_comb begin
    state_next = state_reg;
    tom_next = tom_reg;
    if (one_off && alarm_mode == ALARM_MODE_NONE) begin
      tom_next = 1'b1;
    end
    unique case (state_reg)
      TOR_EXCITED: begin
        if (one_off) begin
          state_next = TOR_REMOVED;
        end
      end
      TOR_REMOVED: begin
        if (both_on) begin
          state_next = TOR_RELEASED;
        end
      end
      TOR_RELEASED: begin
        if (one_off) begin
          state_next = TOR_REMOVED;
        end else if (accept) begin
          state_next = TOR_EXCITED;
          tom_next = 1'b0;
        end
      end
      // an illegal code falls back to the safe state
      default: state_next = TOR_REMOVED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= TOR_EXCITED;
      tom_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tom_reg <= tom_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // all registered, so the far side never sees a decode glitch
  logic in_off_reg, in_off_next;
  logic tom_out_reg, tom_out_next;
  logic dual_reg, dual_next;
  logic edm_reg, edm_next;
  logic excite_reg, excite_next;
  logic rdy_reg, rdy_next;
  logic brake_reg, brake_next;
  logic exc;
  assign exc = (state_next == TOR_EXCITED);

  always_comb begin
    in_off_next = one_off;
    tom_out_next = tom_next;
    dual_next = both_off;
    edm_next = both_off;
    excite_next = exc & son_on;
    rdy_next = exc;
    brake_next = exc & son_on;
  end

  // everything off in reset; readiness follows one edge later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_off_reg <= 1'b0;
      tom_out_reg <= 1'b0;
      dual_reg <= 1'b0;
      edm_reg <= 1'b0;
      excite_reg <= 1'b0;
      rdy_reg <= 1'b0;
      brake_reg <= 1'b0;
    end else begin
      in_off_reg <= in_off_next;
      tom_out_reg <= tom_out_next;
      dual_reg <= dual_next;
      edm_reg <= edm_next;
      excite_reg <= excite_next;
      rdy_reg <= rdy_next;
      brake_reg <= brake_next;
    end
  end

  assign safety_input_off_monitor = in_off_reg;
  assign torque_off_monitor = tom_out_reg;
  assign dual_off_monitor = dual_reg;
  assign external_device_monitor = edm_reg;
  assign motor_excite = excite_reg;
  assign drive_command_ready = rdy_reg;
  assign ready = rdy_reg;
  assign brake_control_output = brake_reg;
endmodule

// ---- bench/tor_safety_module.sv ----
`timescale 1ns/10ps
module tor_safety_module (
  // door and fault controls
  input wire logic door_open,
  input wire logic stuck_b,
  // redundant channels, high means on
  output logic safety_input_a,
  output logic safety_input_b
);
  // a welded contact keeps channel b on
  assign safety_input_a = !door_open;
  assign safety_input_b = !door_open || stuck_b;
endmodule

// ---- bench/tor_core_props.sv ----
`timescale 1ns/10ps
module tor_core_props
  import tor_pkg::*;
#(
  parameter int unsigned LOCKOUT_W = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic servo_on,
  input wire logic torque_off_clear,
  input wire logic alarm_mode,
  input wire logic [1:0] clear_mode,
  input wire logic [LOCKOUT_W-1:0] lockout_ms,
  input wire logic safety_input_off_monitor,
  input wire logic torque_off_monitor,
  input wire logic dual_off_monitor,
  input wire logic external_device_monitor,
  input wire logic motor_excite,
  input wire logic drive_command_ready,
  input wire logic ready,
  input wire logic brake_control_output
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_INPUT_OFF: assert property (safety_input_off_monitor == $past(!(safety_input_a && safety_input_b), 2))
    else $error("input-off monitor wrong");
  AST_DUAL_OFF: assert property (dual_off_monitor == $past(!safety_input_a && !safety_input_b, 2))
    else $error("dual-off monitor wrong");
  AST_EDM: assert property (external_device_monitor == $past(!safety_input_a && !safety_input_b, 2))
    else $error("external monitor wrong");
  AST_TORQUE_SET: assert property ($past(!(safety_input_a && safety_input_b) && !alarm_mode, 2) |-> torque_off_monitor)
    else $error("torque-off monitor not set");
  AST_REMOVED: assert property ($past(!(safety_input_a && safety_input_b), 2) |-> !(ready || motor_excite))
    else $error("excited while an input off");
  AST_READY_PAIR: assert property (ready == drive_command_ready)
    else $error("ready outputs disagree");
  AST_BRAKE: assert property (brake_control_output == motor_excite)
    else $error("brake and excitation disagree");
  AST_RELEASE: assert property ($rose(ready) |-> $past(safety_input_a && safety_input_b, 2))
    else $error("released with an input off");
  AST_LEVEL: assert property ((torque_off_monitor && safety_input_a && safety_input_b && servo_on && torque_off_clear
    && clear_mode == CLR_ON_LEVEL && lockout_ms == '0) [*4] |-> ##[0:4] (ready && !torque_off_monitor))
    else $error("level clear not accepted");
  AST_CLEAR_DROP: assert property ($fell(torque_off_monitor) |-> ready)
    else $error("monitor dropped without excitation");
endmodule
bind tor_core tor_core_props #(.LOCKOUT_W(LOCKOUT_W)) tor_core_props_i (
  .clk(clk), .rstn(rstn), .safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
  .servo_on(servo_on), .torque_off_clear(torque_off_clear), .alarm_mode(alarm_mode), .clear_mode(clear_mode),
  .lockout_ms(lockout_ms), .safety_input_off_monitor(safety_input_off_monitor),
  .torque_off_monitor(torque_off_monitor), .dual_off_monitor(dual_off_monitor),
  .external_device_monitor(external_device_monitor), .motor_excite(motor_excite),
  .drive_command_ready(drive_command_ready), .ready(ready), .brake_control_output(brake_control_output)
);

// ---- bench/test_torque_off_recovery_logic.sv ----
`timescale 1ns/10ps
module test_torque_off_recovery_logic;
  import tor_pkg::*;
  logic clk = 0, rstn = 0, door_open = 0, stuck_b = 0, servo_on = 1, torque_off_clear = 0, stop_input = 0;
  logic alarm_clear_input = 0, alarm_mode = 0, alm_clear_excite_en = 0, son_excite_en = 1, stop_excite_en = 1;
  logic [1:0] clear_mode = CLR_ON_EDGE;
  logic [6:0] lockout_ms = LOCKOUT_DEFAULT_MS;
  logic safety_input_a, safety_input_b, safety_input_off_monitor, torque_off_monitor, dual_off_monitor;
  logic external_device_monitor, motor_excite, drive_command_ready, ready, brake_control_output;
  int fail_count = 0, check_count = 0;
  always #20 clk = ~clk;
  int m_state = 0, m_tom = 0, m_cnt = 0, m_cur = 0, m_prv = 0, m_acc = 0;
  int m_q[$] = '{0};
  tor_safety_module tor_safety_module_i (
    .door_open(door_open), .stuck_b(stuck_b), .safety_input_a(safety_input_a), .safety_input_b(safety_input_b)
  );
  tor_core tor_core_i (
    .clk(clk), .rstn(rstn), .safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
    .servo_on(servo_on), .torque_off_clear(torque_off_clear), .alarm_clear_input(alarm_clear_input),
    .stop_input(stop_input), .alarm_mode(alarm_mode), .clear_mode(clear_mode), .lockout_ms(lockout_ms),
    .alm_clear_excite_en(alm_clear_excite_en), .son_excite_en(son_excite_en), .stop_excite_en(stop_excite_en),
    .safety_input_off_monitor(safety_input_off_monitor), .torque_off_monitor(torque_off_monitor),
    .dual_off_monitor(dual_off_monitor), .external_device_monitor(external_device_monitor),
    .motor_excite(motor_excite), .drive_command_ready(drive_command_ready), .ready(ready),
    .brake_control_output(brake_control_output)
  );
  // reference model, state 0 excited, 1 removed, 2 released; input word is {stop, alarm, clear, servo}
  always @(posedge clk) begin
    if (!rstn) begin
      m_state = 0;
      m_tom = 0;
      m_cnt = 0;
      m_q = '{0};
    end else begin
      m_cur = {stop_input, alarm_clear_input, torque_off_clear, servo_on};
      m_prv = m_q.pop_front();
      m_q.push_back(m_cur);
      m_acc = ((clear_mode == CLR_ON_LEVEL ? m_cur[1] : m_cur[1] && !m_prv[1]) && servo_on
        && m_cnt >= lockout_ms * MS_CYCLES) || (alm_clear_excite_en && m_cur[2] && !m_prv[2])
        || (son_excite_en && m_cur[0] && !m_prv[0]) || (stop_excite_en && m_cur[3] && !m_prv[3]);
      if (!(safety_input_a && safety_input_b)) begin
        if (!alarm_mode) begin
          m_tom = 1;
        end
        m_state = 1;
        m_cnt = 0;
      end else if (m_state == 1) begin
        m_state = 2;
        m_cnt = 0;
      end else if (m_state == 2 && m_acc) begin
        m_state = 0;
        m_tom = 0;
      end else begin
        m_cnt++;
      end
    end
  end
  task automatic cycle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string n, input logic s, input logic e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic cmp(input logic tq, input logic rd);
    chk("in_off", safety_input_off_monitor, !(safety_input_a && safety_input_b));
    chk("dual", dual_off_monitor, !safety_input_a && !safety_input_b);
    chk("edm", external_device_monitor, !safety_input_a && !safety_input_b);
    chk("torque", torque_off_monitor, tq);
    chk("ready", ready, rd);
    chk("excite", motor_excite, rd && servo_on);
    chk("dcr", drive_command_ready, rd);
    chk("brake", brake_control_output, rd && servo_on);
    chk("torque_model", torque_off_monitor, m_tom);
    chk("ready_model", ready, m_state == 0);
  endtask
  task automatic act(input int k);
    case (k)
      0: torque_off_clear = 1;
      1: alarm_clear_input = 1;
      2: servo_on = 1;
      default: stop_input = 1;
    endcase
    cycle(1);
    torque_off_clear = 0;
    alarm_clear_input = 0;
    stop_input = 0;
    cycle(3);
  endtask
  // off time is random, release is always both on
  task automatic off_on();
    door_open = 1;
    cycle(3 + $urandom_range(5));
    cmp(!alarm_mode, 0);
    door_open = 0;
    cycle(3);
    cmp(!alarm_mode, 0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h7694b134));
    cycle(6);
    rstn = 1;
    cycle(3);
    cmp(0, 1);
    stuck_b = 1;
    off_on();
    stuck_b = 0;
    act(0);
    cmp(0, 1);
    $display("test single_off done");
    son_excite_en = 0;
    servo_on = 0;
    off_on();
    act(0);
    cmp(1, 0);
    act(2);
    cmp(1, 0);
    act(0);
    cmp(0, 1);
    $display("test servo_off done");
    for (int e = 0; e < 2; e++) for (int k = 1; k < 4; k++) begin
      {alm_clear_excite_en, son_excite_en, stop_excite_en} = e ? 3'h4 >> (k - 1) : 3'h0;
      servo_on = (k != 2);
      off_on();
      act(k);
      cmp(!e, e);
      servo_on = 1;
      act(0);
      cmp(0, 1);
    end
    $display("test other_inputs done");
    lockout_ms = 7'($urandom_range(2, 1));
    off_on();
    act(0);
    cmp(1, 0);
    cycle(lockout_ms * MS_CYCLES);
    act(0);
    cmp(0, 1);
    lockout_ms = 7'h00;
    $display("test lockout done");
    clear_mode = CLR_ON_LEVEL;
    off_on();
    torque_off_clear = 1;
    cycle(6);
    cmp(0, 1);
    torque_off_clear = 0;
    alarm_mode = 1;
    off_on();
    act(0);
    cmp(0, 1);
    $display("test level_alarm done");
    tally_and_finish();
  end
endmodule
